// File: core/agc_pkg.sv
/*
 package for the address generation and canonical check block: mode codes,
 segment codes, address sizes and widths. assumes no other package.
*/
package agc_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W     = 64;
	localparam int IMPL_BITS  = 48;
	localparam int DISP_W     = 32;
	localparam int SEL_W      = 16;
	localparam int PHYS_W     = 64;
	localparam logic [63:0] MAX16 = 64'h0000_0000_0000_FFFF;
	localparam logic [63:0] MAX32 = 64'h0000_0000_FFFF_FFFF;
	localparam logic [63:0] MAX20 = 64'h0000_0000_000F_FFFF;

	// ----------------------------------------------------------------
	// operating modes
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		AGC_MODE_REAL   = 5'h01,
		AGC_MODE_PROT   = 5'h02,
		AGC_MODE_COMPAT = 5'h04,
		AGC_MODE_LONG   = 5'h08,
		AGC_MODE_SMM    = 5'h10
	} agc_mode_t;

	// ----------------------------------------------------------------
	// address sizes and segments
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		AGC_AS_16 = 2'h0,
		AGC_AS_32 = 2'h1,
		AGC_AS_64 = 2'h2
	} agc_asize_t;

	typedef enum logic [2:0] {
		AGC_SEG_ES  = 3'h0,
		AGC_SEG_CS  = 3'h1,
		AGC_SEG_SS  = 3'h2,
		AGC_SEG_DS  = 3'h3,
		AGC_SEG_AUX1 = 3'h4,
		AGC_SEG_AUX2 = 3'h5
	} agc_seg_t;
endpackage

// File: core/agc_core.sv
/*
 address generation with size truncation, segment base add, instruction
 pointer widening and canonical check. assumes decode supplies operands,
 mode and per-instruction prefixes together with a one-cycle req pulse,
 and that a paging unit consumes the linear address when paging is on.
*/
`timescale 1ns/100ps

// Operation
// - long mode default: 64-bit effective address
// - long mode: code/data/extra/stack bases zero
// - aux segment: truncate first, add full base
// - instruction pointer held 64 bits wide
// - displacements 32-bit sign-extended; move-form 64-bit
// - truncate to address size, zero-extend
// - canonical: bits 63..top implemented bit equal
// - non-canonical reference raises general-protection fault
// - stack references raise stack fault instead
// - stack base with aux override: general fault
// - long mode ignores legacy segment overrides
// - protected mode caps at 16/32-bit maximum
// - logical address: selector plus sized offset
// - default sizes from code descriptor, prefix overrides
// - real mode 16-bit default, 20-bit limit
// - paging off: linear drives physical unchanged
// - long mode maps through extended paging
// - management mode uses separate memory space
// - compatibility mode segments like protected mode
module agc_core #(
	parameter int IMPL_BITS = agc_pkg::IMPL_BITS
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic                  req,
	input  agc_pkg::agc_mode_t         mode,
	input  wire logic                  cs_default_32,
	input  wire logic                  addr_size_ovr,
	input  wire logic                  seg_ovr_valid,
	input  agc_pkg::agc_seg_t          seg_ovr,
	input  wire logic                  use_base,
	input  wire logic [63:0]           base_val,
	input  wire logic                  base_is_stack,
	input  wire logic                  use_index,
	input  wire logic [63:0]           index_val,
	input  wire logic [1:0]            scale_log2,
	input  wire logic [63:0]           disp_val,
	input  wire logic                  disp_is_moffs64,
	input  wire logic                  implied_stack,
	input  wire logic [15:0]           selector,
	input  wire logic [63:0]           seg_base_aux1,
	input  wire logic [63:0]           seg_base_aux2,
	input  wire logic [63:0]           seg_base_legacy,
	input  wire logic                  paging_en,
	input  wire logic                  system_mgmt_mode,
	input  wire logic                  ip_load,
	input  wire logic [63:0]           ip_load_val,
	input  wire logic                  ip_advance,
	input  wire logic [3:0]            ip_len,
	output logic                       valid,
	output logic [63:0]                eff_addr,
	output logic [63:0]                lin_addr,
	output logic [63:0]                phys_addr,
	output logic                       to_paging,
	output logic                       system_mgmt_memory,
	output logic [15:0]                logical_sel,
	output logic [31:0]                logical_off,
	output logic                       general_protection_fault,
	output logic                       stack_canonical_fault,
	output logic [63:0]                instr_pointer_64,
	output logic [31:0]                instr_pointer_32,
	output logic [15:0]                instr_pointer_16
);
	// ----------------------------------------------------------------
	// mode decode and effective address size
	// ----------------------------------------------------------------
	wire logic is_long   = (mode == agc_pkg::AGC_MODE_LONG);
	wire logic is_real   = (mode == agc_pkg::AGC_MODE_REAL) | system_mgmt_mode;
	wire logic is_compat = (mode == agc_pkg::AGC_MODE_COMPAT);
	wire logic def_32    = is_compat ? cs_default_32 : (cs_default_32 & ~is_real);

	agc_pkg::agc_asize_t asize;
	assign asize = is_long ? (addr_size_ovr ? agc_pkg::AGC_AS_32 : agc_pkg::AGC_AS_64)
		: ((def_32 ^ addr_size_ovr) ? agc_pkg::AGC_AS_32 : agc_pkg::AGC_AS_16);

	// ----------------------------------------------------------------
	// effective address sum
	// ----------------------------------------------------------------
	// long mode sign-extends the 32-bit field; the move form carries all 64 bits
	wire logic [63:0] disp_ext = (is_long & disp_is_moffs64) ? disp_val
		: {{32{disp_val[31]}}, disp_val[31:0]};
	wire logic [63:0] base_term  = use_base ? base_val : 64'h0;
	wire logic [63:0] index_term = use_index ? (index_val << scale_log2) : 64'h0;
	wire logic [63:0] ea_sum     = base_term + index_term + disp_ext;

	// truncate to the current size, then zero-extend
	wire logic [63:0] ea_trunc = (asize == agc_pkg::AGC_AS_64) ? ea_sum
		: (asize == agc_pkg::AGC_AS_32) ? (ea_sum & agc_pkg::MAX32)
		: (ea_sum & agc_pkg::MAX16);

	// ----------------------------------------------------------------
	// segment selection
	// ----------------------------------------------------------------
	// only the two aux overrides survive in long mode
	wire logic aux_ovr = seg_ovr_valid & ((seg_ovr == agc_pkg::AGC_SEG_AUX1)
		| (seg_ovr == agc_pkg::AGC_SEG_AUX2));
	wire logic eff_ovr = is_long ? aux_ovr : seg_ovr_valid;
	wire logic [63:0] aux_base = (seg_ovr == agc_pkg::AGC_SEG_AUX1) ? seg_base_aux1
		: seg_base_aux2;
	wire logic [63:0] ovr_base = aux_ovr ? aux_base : seg_base_legacy;

	// long mode: legacy bases read as zero, aux base is never truncated
	wire logic [63:0] seg_add = is_long ? (aux_ovr ? aux_base : 64'h0)
		: (eff_ovr ? ovr_base : seg_base_legacy);

	wire logic [63:0] lin_raw = ea_trunc + seg_add;
	// legacy modes wrap at 32 bits; real mode stays in the 20-bit space
	wire logic [63:0] lin_next = is_long ? lin_raw
		: is_real ? (lin_raw & agc_pkg::MAX20)
		: (lin_raw & agc_pkg::MAX32);

	// ----------------------------------------------------------------
	// canonical check and fault routing
	// ----------------------------------------------------------------
	wire logic [64-IMPL_BITS:0] top_bits = lin_next[63:IMPL_BITS-1];
	wire logic canonical = (&top_bits) | ~(|top_bits);
	wire logic stack_ref = (implied_stack | (use_base & base_is_stack)) & ~eff_ovr;
	wire logic bad = is_long & ~canonical;
	wire logic next_gp = bad & ~stack_ref;
	wire logic next_sf = bad & stack_ref;

	// ----------------------------------------------------------------
	// result registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			valid                    <= 1'b0;
			eff_addr                 <= 64'h0;
			lin_addr                 <= 64'h0;
			phys_addr                <= 64'h0;
			to_paging                <= 1'b0;
			system_mgmt_memory       <= 1'b0;
			logical_sel              <= 16'h0;
			logical_off              <= 32'h0;
			general_protection_fault <= 1'b0;
			stack_canonical_fault    <= 1'b0;
		end else begin
			valid                    <= req;
			general_protection_fault <= req & next_gp;
			stack_canonical_fault    <= req & next_sf;
			if (req) begin
				eff_addr           <= ea_trunc;
				lin_addr           <= lin_next;
				// long mode always goes through extended paging
				to_paging          <= paging_en | is_long;
				phys_addr          <= (paging_en | is_long) ? 64'h0 : lin_next;
				system_mgmt_memory <= system_mgmt_mode;
				logical_sel        <= selector;
				logical_off        <= (asize == agc_pkg::AGC_AS_16)
					? {16'h0, ea_trunc[15:0]} : ea_trunc[31:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// instruction pointer
	// ----------------------------------------------------------------
	wire logic [63:0] ip_sum = instr_pointer_64 + {60'h0, ip_len};
	// outside long mode, 16-bit address size keeps the upper bits, 32-bit address size zero-extends
	wire logic [63:0] ip_next = is_long ? ip_sum
		: (asize == agc_pkg::AGC_AS_32) ? {32'h0, ip_sum[31:0]}
		: {instr_pointer_64[63:16], ip_sum[15:0]};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			instr_pointer_64 <= 64'h0;
		end else if (ip_load) begin
			instr_pointer_64 <= ip_load_val;
		end else if (ip_advance) begin
			instr_pointer_64 <= ip_next;
		end
	end

	assign instr_pointer_32 = instr_pointer_64[31:0];
	assign instr_pointer_16 = instr_pointer_64[15:0];
endmodule // agc_core

// File: testbench/agc_checker.sv
/* port assertions for agc_core. assumes a by-name bind from the bench top. */
`timescale 1ns/100ps
module agc_checker #(parameter int IMPL_BITS = 48) (
	input wire logic ref_clk, rst, req, valid, to_paging, implied_stack, base_is_stack, paging_en,
	input wire logic general_protection_fault, stack_canonical_fault,
	input wire agc_pkg::agc_mode_t mode,
	input wire logic [63:0] lin_addr, phys_addr, instr_pointer_64,
	input wire logic [31:0] instr_pointer_32,
	input wire logic [15:0] instr_pointer_16);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [4:0] pm;
	wire g = general_protection_fault;
	wire s = stack_canonical_fault;
	wire lng = pm == 5'h08;
	wire canon = &lin_addr[63:IMPL_BITS-1] | ~|lin_addr[63:IMPL_BITS-1];
	// mode of the request that the current answer belongs to
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) pm <= 5'h00;
		else pm <= mode;
	end
	a_valid_late: assert property (req |=> valid) else $error("no answer after request");
	a_canon_fault: assert property (valid && lng && !canon |-> g ^ s) else $error("bad fault");
	a_canon_clean: assert property (valid && lng && canon |-> !g && !s) else $error("fault");
	a_fault_valid: assert property (g || s |-> valid) else $error("fault without valid");
	a_stack_cause: assert property (s |-> $past(implied_stack || base_is_stack)) else $error("sf");
	a_long_paged: assert property (valid && lng |-> to_paging) else $error("not paged");
	a_flat_phys: assert property (valid && !lng && !$past(paging_en) |-> phys_addr == lin_addr)
		else $error("phys differs");
	a_real_limit: assert property (valid && pm == 5'h01 |-> lin_addr[63:20] == '0) else $error("real");
	a_prot_cap: assert property (valid && pm inside {5'h02, 5'h04} |-> lin_addr[63:32] == '0)
		else $error("prot cap");
	a_ip_slices: assert property (instr_pointer_32 == instr_pointer_64[31:0]
		&& instr_pointer_16 == instr_pointer_64[15:0]) else $error("ip slices");
	c_gp: cover property (valid && g);
	c_sf: cover property (valid && s);
	c_paged: cover property (valid && lng && to_paging);
endmodule // agc_checker

// File: testbench/agc_pager.sv
/* paging unit stand-in: keeps the last address routed to paging. one clock. */
`timescale 1ns/100ps
module agc_pager (
	input wire logic ref_clk, rst, valid, to_paging,
	input wire logic [63:0] lin_addr,
	output logic [63:0] seen);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) seen <= '0;
		else if (valid && to_paging) seen <= lin_addr;
	end
endmodule // agc_pager

// File: testbench/tb_top.sv
/* bench for agc_core with paging stand-in. assumes agc_pkg compiled first. */
`timescale 1ns/100ps
module tb_top;
	logic ref_clk = 0, rst = 1, req = 0, use_base = 1, use_index = 1, ip_load = 0, ip_advance = 0;
	logic cs_default_32 = 0, addr_size_ovr = 0, seg_ovr_valid = 0, base_is_stack = 0;
	logic disp_is_moffs64 = 0, implied_stack = 0, paging_en = 0, system_mgmt_mode = 0;
	agc_pkg::agc_mode_t mode = agc_pkg::AGC_MODE_REAL;
	agc_pkg::agc_seg_t seg_ovr = agc_pkg::AGC_SEG_ES;
	logic [63:0] base_val = 0, index_val = 0, disp_val = 0, seg_base_aux1 = 0, seg_base_aux2 = 0;
	logic [63:0] seg_base_legacy = 64'h1_0000, ip_load_val = 0, seen;
	logic [15:0] selector = 16'h0;
	logic [1:0] scale_log2 = 2'h2;
	logic [3:0] ip_len = 4'h0;
	logic valid, to_paging, system_mgmt_memory, general_protection_fault, stack_canonical_fault;
	logic [63:0] eff_addr, lin_addr, phys_addr, instr_pointer_64;
	logic [31:0] logical_off, instr_pointer_32;
	logic [15:0] logical_sel, instr_pointer_16;
	int errors = 0, total_checks = 0;
	agc_core #(.IMPL_BITS(48)) dut (.*);
	agc_pager pager (.*);
	initial forever #4 ref_clk = ~ref_clk;
	task chk(input logic [63:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// f: paging, size prefix, cs32, mgmt, stack base, implied stack, moffs
	task op(input logic [4:0] m, input logic [63:0] b, i, d, input logic [6:0] f,
		input logic sv, input logic [2:0] s);
		mode <= agc_pkg::agc_mode_t'(m);
		base_val <= b;
		index_val <= i;
		disp_val <= d;
		{paging_en, addr_size_ovr, cs_default_32, system_mgmt_mode, base_is_stack, implied_stack,
			disp_is_moffs64} <= f;
		seg_ovr_valid <= sv;
		seg_ovr <= agc_pkg::agc_seg_t'(s);
		req <= 1;
		@(posedge ref_clk);
		req <= 0;
		#1;
	endtask
	task t_long;
		@(posedge ref_clk); op(5'h08, 64'h1234_0000_0000, 64'h10, 64'hAAAA_AAAA_FFFF_FFF0, 7'h40, 0, 0);
		chk(eff_addr, 64'h1234_0000_0030);
		chk(lin_addr, 64'h1234_0000_0030);
		@(posedge ref_clk); op(5'h08, 0, 0, 64'h7000_0000_0001, 7'h41, 0, 0);
		chk(eff_addr, 64'h7000_0000_0001);
		chk(seen, 64'h1234_0000_0030);
		chk(to_paging, 1);
		chk(phys_addr, 0);
	endtask
	task t_aux;
		@(posedge ref_clk); seg_base_aux1 <= 64'h1234_5678_0000;
		op(5'h08, 64'hFFFF_FFFF, 0, 1, 7'h60, 1, 3'h4);
		chk(eff_addr, 0);
		chk(lin_addr, 64'h1234_5678_0000);
	endtask
	task cn(input logic [63:0] b, input logic [6:0] f, input logic sv, input logic [2:0] s, e);
		@(posedge ref_clk); op(5'h08, b, 0, 0, f, sv, s);
		chk({general_protection_fault, stack_canonical_fault}, e[1:0]);
	endtask
	task t_real;
		@(posedge ref_clk); op(5'h01, 64'h1234_5678, 0, 0, 7'h20, 0, 0);
		chk(lin_addr, 64'h5_5678);
		chk(phys_addr, 64'h5_5678);
		@(posedge ref_clk); op(5'h01, 64'h1_2345, 0, 0, 7'h00, 0, 0);
		chk(lin_addr, 64'h1_2345);
		@(posedge ref_clk); op(5'h10, 0, 0, 0, 7'h08, 0, 0);
		chk(system_mgmt_memory, 1);
	endtask
	task t_prot;
		@(posedge ref_clk); selector <= 16'hA5C3; op(5'h02, 64'h1_2345, 0, 0, 7'h00, 0, 0);
		chk(eff_addr, 64'h2345);
		chk({logical_sel, logical_off}, 48'hA5C3_0000_2345);
		@(posedge ref_clk); op(5'h02, 64'h1_2345, 0, 0, 7'h30, 0, 0);
		chk(eff_addr, 64'h2345);
		@(posedge ref_clk); op(5'h02, 64'h1_2345, 0, 0, 7'h10, 0, 0);
		chk(eff_addr, 64'h1_2345);
		@(posedge ref_clk); op(5'h04, 64'h1_FFFF_0000, 0, 0, 7'h10, 0, 0);
		chk(lin_addr, 0);
	endtask
	task t_ip;
		@(posedge ref_clk); ip_load <= 1; ip_load_val <= 64'h8000_0000_0010; mode <= agc_pkg::AGC_MODE_LONG;
		@(posedge ref_clk); ip_load <= 0; ip_advance <= 1; ip_len <= 4'h3; #1;
		chk(instr_pointer_64, 64'h8000_0000_0010);
		@(posedge ref_clk); ip_advance <= 0; #1;
		chk(instr_pointer_64, 64'h8000_0000_0013);
		chk(instr_pointer_32, 64'h13);
		chk(instr_pointer_16, 64'h13);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 0;
		t_long;
		t_aux;
		cn(64'h8000_0000_0000, 7'h40, 0, 3'h0, 2);
		cn(64'h8000_0000_0000, 7'h42, 0, 3'h0, 1);
		cn(64'h8000_0000_0000, 7'h44, 1, 3'h4, 2);
		cn(64'h8000_0000_0000, 7'h40, 1, 3'h2, 2);
		cn(64'h8000_0000_0000, 7'h44, 1, 3'h3, 1);
		cn(64'hFFFF_8000_0000_0000, 7'h44, 0, 3'h0, 0);
		cn(64'h7FFF_FFFF_FFFF, 7'h40, 0, 3'h0, 0);
		t_real;
		t_prot;
		t_ip;
		finish_test;
	end
	initial begin
		repeat (500) @(posedge ref_clk);
		errors++;
		finish_test;
	end
endmodule // tb_top
bind agc_core agc_checker #(.IMPL_BITS(IMPL_BITS)) chk (.*);
